// ---- src/cer_pkg.sv ----
/*
  Constants for the camera exposure and readout controller: register
  indices, field positions, reset values and timing counts.
  Assumes a 100 MHz core clock.
*/
package cer_pkg;
  // clock and timing
  localparam int CLK_NS = 10;
  localparam int LINE_NS = 31250;            // one line period
  localparam int LINE_CYC = LINE_NS / CLK_NS;
  localparam int LVAL_NS = 27840;            // active part of a line
  localparam int LVAL_CYC = LVAL_NS / CLK_NS;
  localparam int US_NS = 1000;               // exposure time base
  localparam int US_CYC = US_NS / CLK_NS;
  localparam logic [15:0] LINE_US = 16'(LINE_NS / US_NS); // whole us per line
  localparam logic [15:0] PW_TAIL_US = 16'h0005; // pulse-width extra time
  // frame geometry in rows
  localparam logic [10:0] FULL_FIRST = 11'h000;
  localparam logic [10:0] FULL_LAST = 11'h40f;   // 1039
  localparam logic [10:0] PART_FIRST = 11'h140;  // 320
  localparam logic [10:0] PART_LAST = 11'h2cf;   // 719
  localparam logic [10:0] DRAFT_STEP = 11'h007;  // jump to next group of 8
  localparam logic [2:0] DRAFT_KEEP = 3'h2;      // rows kept per group
  // register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SETUP = 4'h1;
  localparam logic [3:0] REG_SHUTTER = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  // control field positions
  localparam int CTRL_PART = 0;
  localparam int CTRL_DRAFT = 1;
  localparam int CTRL_EXPOSURE_TRIGGER_IN_EN = 2;
  localparam int CTRL_POL_POS = 3;
  localparam int CTRL_PW_MODE = 4;
  localparam int CTRL_MULTI = 5;
  localparam int CTRL_SRC_AUX = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // black level offset limits and reset
  localparam logic signed [15:0] SETUP_MIN = -16'sd248;
  localparam logic signed [15:0] SETUP_MAX = 16'sd511;
  localparam logic [9:0] SETUP_RST = 10'h000;
  // shutter in microseconds
  localparam logic [15:0] SHUT_MIN_US = 16'h0064;   // 1/10000 s
  localparam logic [15:0] SHUT_MAX_US = 16'h8235;   // 1/30 s
  localparam logic [15:0] SHUT_RST = 16'h8235;
  // controller states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_FIX   = 8'h02,
    ST_PW    = 8'h04,
    ST_TAIL  = 8'h08,
    ST_ACC   = 8'h10,
    ST_REQ   = 8'h20,
    ST_ALIGN = 8'h40,
    ST_READ  = 8'h80
  } cer_state_t;
endpackage : cer_pkg

// ---- src/cer_ctrl.sv ----
/*
  Exposure and readout sequencer of a progressive-scan camera: readout
  mode selection, triggered exposure, multiple exposure, frame and line
  valid, a two-entry row buffer and a small register port.
  Assumes control lines from the frame grabber change on link_clk and the
  auxiliary trigger is fully asynchronous; both are synchronised here.
*/
// How it works
// RULE1: centre-window and draft readout can never be enabled together.
// RULE2: full readout outputs every effective row once per frame.
// RULE3: centre-window readout outputs only the middle 400 rows.
// RULE4: draft readout outputs two rows of every eight across the area.
// RULE5: black-level offset is clamped to a signed -248..+511 range.
// RULE6: trigger comes from control line one or the auxiliary connector.
// RULE7: negative polarity starts exposure on the trigger falling edge.
// RULE8: positive polarity starts exposure on the trigger rising edge.
// RULE9: fixed mode exposure lasts the shutter setting, not the pulse.
// RULE10: frame valid rises with the next line valid after exposure.
// RULE11: pulse-width mode exposes for the pulse plus five microseconds.
// RULE12: the source holds a pulse-width trigger at least one line.
// RULE13: multiple exposure only acts while triggered shutter is on.
// RULE14: the multiple-exposure readout request is control line two.
// RULE15: exposures before a readout request accumulate into one image.
// RULE16: each accumulated exposure follows fixed or pulse-width timing.
// RULE17: the request is active low, one line up to ten milliseconds.
// RULE18: frame valid follows the next line valid after the request ends.
`timescale 1ns/1ps
module cer_ctrl
  import cer_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic link_clk,
  input wire logic cc1_in,
  input wire logic cc2_in,
  input wire logic aux_exposure_trigger_in_in,
  output logic frame_valid,
  output logic line_valid,
  output logic exposing,
  output logic [10:0] row_data,
  output logic row_valid,
  input wire logic row_ready
);
  import cer_pkg::*;
  logic [CTRL_W-1:0] ctrl_r;
  logic [9:0] setup_r;
  logic [15:0] shutter_r;
  logic [15:0] rdata_r;
  cer_state_t st_r, st_nxt;
  logic [2:0] lclk_r, cc1_r, cc2_r, aux_r;
  logic cc1_s_r, cc2_s_r, exposure_trigger_in_prev_r, req_prev_r;
  logic [11:0] line_cnt_r;
  logic [6:0] us_cnt_r;
  logic [15:0] exp_cnt_r;
  logic [7:0] acc_cnt_r;
  logic [10:0] row_r;
  logic last_r, fval_r, lval_r, expo_r;
  logic [10:0] buf_q [0:1];
  logic [1:0] buf_v_r;
  // synchronisers: stage 0 feeds stage 1 only
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lclk_r <= 3'h0;
      cc1_r <= 3'h0;
      cc2_r <= 3'h7;
      aux_r <= 3'h0;
    end
    else
    begin
      lclk_r <= {lclk_r[1:0], link_clk};
      cc1_r <= {cc1_r[1:0], cc1_in};
      cc2_r <= {cc2_r[1:0], cc2_in};
      aux_r <= {aux_r[1:0], aux_exposure_trigger_in_in};
    end
  end

  // grabber lines are taken on a rising link clock edge
  wire link_rise = lclk_r[1] & ~lclk_r[2];
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cc1_s_r <= 1'b0;
      cc2_s_r <= 1'b1;
    end
    else if (link_rise)
    begin
      cc1_s_r <= cc1_r[1];
      cc2_s_r <= cc2_r[1]; // RULE14
    end
  end

  // control decode
  wire part_on = ctrl_r[CTRL_PART];
  wire draft_on = ctrl_r[CTRL_DRAFT];
  wire exposure_trigger_in_on = ctrl_r[CTRL_EXPOSURE_TRIGGER_IN_EN];
  wire pw_on = ctrl_r[CTRL_PW_MODE];
  wire multi_on = exposure_trigger_in_on & ctrl_r[CTRL_MULTI]; // RULE13
  wire exposure_trigger_in_lvl = ctrl_r[CTRL_SRC_AUX] ? aux_r[2] : cc1_s_r; // RULE6
  // active level follows polarity, so both edges reduce to a rise here
  wire exposure_trigger_in_act = ctrl_r[CTRL_POL_POS] ? exposure_trigger_in_lvl : ~exposure_trigger_in_lvl; // RULE7 RULE8
  wire exposure_trigger_in_start = exposure_trigger_in_act & ~exposure_trigger_in_prev_r;
  wire req_act = ~cc2_s_r; // RULE17
  wire req_end = ~req_act & req_prev_r;

  // time bases; microsecond phase restarts per state so exposures are exact
  wire line_tick = (line_cnt_r == 12'(LINE_CYC - 1));
  wire us_tick = (us_cnt_r == 7'(US_CYC - 1));
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_cnt_r <= 12'h000;
      us_cnt_r <= 7'h00;
      exposure_trigger_in_prev_r <= 1'b0;
      req_prev_r <= 1'b0;
    end
    else
    begin
      line_cnt_r <= line_tick ? 12'h000 : line_cnt_r + 12'h001;
      us_cnt_r <= (us_tick || st_nxt != st_r) ? 7'h00 : us_cnt_r + 7'h01;
      exposure_trigger_in_prev_r <= exposure_trigger_in_act;
      req_prev_r <= req_act;
    end
  end

  // register writes; a write asking for both window modes keeps the old mode bits
  wire wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
  wire both_modes = reg_wdata[CTRL_PART] & reg_wdata[CTRL_DRAFT];
  wire [CTRL_W-1:0] ctrl_wv = both_modes ?
    {reg_wdata[CTRL_W-1:2], ctrl_r[1:0]} : reg_wdata[CTRL_W-1:0]; // RULE1
  wire signed [15:0] setup_in = $signed(reg_wdata);
  wire [15:0] setup_cl = (setup_in < SETUP_MIN) ? SETUP_MIN :
    (setup_in > SETUP_MAX) ? SETUP_MAX : reg_wdata; // RULE5
  wire [15:0] shut_cl = (reg_wdata < SHUT_MIN_US) ? SHUT_MIN_US :
    (reg_wdata > SHUT_MAX_US) ? SHUT_MAX_US : reg_wdata;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r <= CTRL_RST;
      setup_r <= SETUP_RST;
      shutter_r <= SHUT_RST;
    end
    else if (reg_wr)
    begin
      if (wr_ctrl)
        ctrl_r <= ctrl_wv;
      if (reg_addr == REG_SETUP)
        setup_r <= setup_cl[9:0];
      if (reg_addr == REG_SHUTTER)
        shutter_r <= shut_cl;
    end
  end

  // read mux; unmapped indices read zero
  wire [15:0] status_w = {acc_cnt_r, st_r};
  wire [15:0] rd_mux =
    (reg_addr == REG_CTRL) ? {9'h000, ctrl_r} :
    (reg_addr == REG_SETUP) ? {{6{setup_r[9]}}, setup_r} :
    (reg_addr == REG_SHUTTER) ? shutter_r :
    (reg_addr == REG_STATUS) ? status_w : 16'h0000;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= 16'h0000;
    else
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
  end

  // row walk per readout mode
  wire [10:0] row_first = part_on ? PART_FIRST : FULL_FIRST; // RULE3
  wire [10:0] row_last = part_on ? PART_LAST : FULL_LAST; // RULE2
  wire draft_jump = draft_on & (row_r[2:0] == DRAFT_KEEP - 3'h1);
  wire [10:0] row_next = row_r + (draft_jump ? DRAFT_STEP : 11'h001); // RULE4
  wire buf_ready = ~buf_v_r[1];
  wire push = (st_r == ST_READ) & line_tick & ~last_r & buf_ready;
  wire pop = buf_v_r[0] & row_ready;
  wire exp_end_fix = us_tick & (exp_cnt_r >= shutter_r - 16'h0001);
  wire exp_end_tail = us_tick & (exp_cnt_r >= PW_TAIL_US - 16'h0001);
  wire exp_done = (st_r == ST_FIX && exp_end_fix) ||
    (st_r == ST_TAIL && exp_end_tail);

  // sequencer next state
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (!exposure_trigger_in_on)
          st_nxt = ST_ALIGN;
        else if (exposure_trigger_in_start)
          st_nxt = pw_on ? ST_PW : ST_FIX; // RULE16
      ST_FIX:
        if (exp_end_fix)
          st_nxt = multi_on ? ST_ACC : ST_ALIGN; // RULE9
      ST_PW:
        if (!exposure_trigger_in_act)
          st_nxt = ST_TAIL; // RULE12
      ST_TAIL:
        if (exp_end_tail)
          st_nxt = multi_on ? ST_ACC : ST_ALIGN; // RULE11
      ST_ACC:
        if (!multi_on)
          st_nxt = ST_ALIGN;
        else if (req_act)
          st_nxt = ST_REQ;
        else if (exposure_trigger_in_start)
          st_nxt = pw_on ? ST_PW : ST_FIX; // RULE15
      ST_REQ:
        if (req_end)
          st_nxt = ST_ALIGN; // RULE18
      ST_ALIGN:
        if (line_tick)
          st_nxt = ST_READ; // RULE10
        else if (exposure_trigger_in_on && acc_cnt_r == 8'h00) // free run yields to trigger
          st_nxt = ST_IDLE;
      ST_READ:
        if (line_tick && last_r)
          st_nxt = ST_IDLE;
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  // state, exposure counters and accumulation count
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= ST_IDLE;
      exp_cnt_r <= 16'h0000;
      acc_cnt_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_nxt != st_r)
        exp_cnt_r <= 16'h0000;
      else if (us_tick)
        exp_cnt_r <= exp_cnt_r + 16'h0001;
      if (exp_done)
        acc_cnt_r <= acc_cnt_r + 8'h01; // RULE15
      else if (st_r == ST_READ && st_nxt == ST_IDLE)
        acc_cnt_r <= 8'h00;
    end
  end

  // frame and line valid; frame valid only ever rises on a line start
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fval_r <= 1'b0;
      lval_r <= 1'b0;
      expo_r <= 1'b0;
      row_r <= 11'h000;
      last_r <= 1'b0;
    end
    else
    begin
      expo_r <= (st_nxt == ST_FIX) | (st_nxt == ST_PW) | (st_nxt == ST_TAIL);
      if (line_tick)
        lval_r <= 1'b1;
      else if (line_cnt_r == 12'(LVAL_CYC - 1))
        lval_r <= 1'b0;
      if (st_r == ST_ALIGN && line_tick)
      begin
        fval_r <= 1'b1; // RULE10
        row_r <= row_first;
        last_r <= 1'b0;
      end
      else if (st_r == ST_READ && line_tick && last_r)
        fval_r <= 1'b0;
      else if (push)
      begin
        // a stalled line is retried on the next line, never skipped
        row_r <= row_next;
        last_r <= (row_r == row_last) || (row_next > row_last);
      end
    end
  end

  // two-entry row buffer: entry 0 faces the receiver
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buf_v_r <= 2'h0;
      buf_q[0] <= 11'h000;
      buf_q[1] <= 11'h000;
    end
    else
    begin
      if (pop)
      begin
        buf_q[0] <= buf_v_r[1] ? buf_q[1] : row_r;
        buf_v_r[0] <= buf_v_r[1] | push;
        buf_v_r[1] <= buf_v_r[1] & push;
        if (buf_v_r[1] && push)
          buf_q[1] <= row_r;
      end
      else if (push)
      begin
        if (!buf_v_r[0])
        begin
          buf_q[0] <= row_r;
          buf_v_r[0] <= 1'b1;
        end
        else
        begin
          buf_q[1] <= row_r;
          buf_v_r[1] <= 1'b1;
        end
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign frame_valid = fval_r;
  assign line_valid = lval_r;
  assign exposing = expo_r;
  assign row_data = buf_q[0];
  assign row_valid = buf_v_r[0];
  // checks
  a_modes_exclusive: assert property (@(posedge core_clk) disable iff
    (!reset_n) !(part_on && draft_on)) // RULE1
    else $error("window and draft modes both enabled");
  a_setup_in_range: assert property (@(posedge core_clk) disable iff
    (!reset_n) $signed(setup_r) >= -10'sd248) // RULE5
    else $error("black level offset below range");
  a_frame_with_line: assert property (@(posedge core_clk) disable iff
    (!reset_n) $rose(fval_r) |-> $rose(lval_r)) // RULE10
    else $error("frame valid rose without line valid");
  a_fixed_exposure_len: assert property (@(posedge core_clk) disable iff
    (!reset_n) (st_r == ST_FIX && st_nxt != ST_FIX)
    |-> exp_cnt_r + 16'h0001 >= shutter_r) // RULE9
    else $error("fixed exposure ended early");
  a_tail_exposure_len: assert property (@(posedge core_clk) disable iff
    (!reset_n) $rose(st_r == ST_TAIL) |-> ##[480:520] st_r != ST_TAIL)
    // RULE11
    else $error("pulse-width tail not about five microseconds");
  a_multi_gated: assert property (@(posedge core_clk) disable iff
    (!reset_n) $rose(st_r == ST_ACC) |-> $past(multi_on)) // RULE13
    else $error("accumulation without multiple exposure mode");
  a_request_to_frame: assert property (@(posedge core_clk) disable iff
    (!reset_n) (st_r == ST_REQ && req_end) |=> st_r == ST_ALIGN) // RULE18
    else $error("no alignment after readout request");
  a_align_bounded: assert property (@(posedge core_clk) disable iff // RULE18
    (!reset_n) st_r == ST_ALIGN |-> exp_cnt_r <= LINE_US)
    else $error("frame start waited longer than one line");
  a_draft_rows: assert property (@(posedge core_clk) disable iff
    (!reset_n) (push && draft_on) |-> row_r[2:0] < DRAFT_KEEP) // RULE4
    else $error("draft mode output a skipped row");
  a_window_rows: assert property (@(posedge core_clk) disable iff
    (!reset_n) (push && part_on) |-> row_r >= PART_FIRST &&
    row_r <= PART_LAST) // RULE3
    else $error("window mode row outside centre area");
  a_trigger_starts: assert property (@(posedge core_clk) disable iff
    (!reset_n) (st_r == ST_IDLE && exposure_trigger_in_on && exposure_trigger_in_start) |=> expo_r)
    // RULE7 RULE8
    else $error("trigger edge did not start exposure");
endmodule : cer_ctrl

// ---- dv/cer_grabber.sv ----
/*
  Frame grabber and trigger source model: link clock, control lines one
  and two, and the auxiliary trigger input.
  Assumes the controller samples control lines on link_clk rises.
*/
`timescale 1ns/1ps
module cer_grabber (
  output logic link_clk,
  output logic cc1_in,
  output logic cc2_in,
  output logic aux_exposure_trigger_in_in
);
  // link clock runs free, like a pixel clock; request line idles high
  initial
  begin
    link_clk = 1'b0;
    cc1_in = 1'b0;
    cc2_in = 1'b1;
    aux_exposure_trigger_in_in = 1'b0;
    forever #40 link_clk = ~link_clk;
  end

  // level change just after a link edge, so it is held a whole period
  task set_line(input logic use_aux, input logic lvl);
    @(posedge link_clk);
    if (use_aux)
      aux_exposure_trigger_in_in <= lvl;
    else
      cc1_in <= lvl;
  endtask : set_line

  // one trigger pulse; never shorter than one line, even in fixed mode
  task pulse(input logic use_aux, input logic act, input int ns);
    int w;
    w = (ns < 31250) ? 31250 : ns;
    set_line(use_aux, act);
    #(w);
    set_line(use_aux, ~act);
  endtask : pulse

  // readout request, active low, one line up to ten milliseconds
  task request(input int ns);
    int w;
    w = (ns < 31250) ? 31250 : ((ns > 10000000) ? 10000000 : ns);
    @(posedge link_clk);
    cc2_in <= 1'b0;
    #(w);
    @(posedge link_clk);
    cc2_in <= 1'b1;
  endtask : request
endmodule : cer_grabber

// ---- dv/test_camera_exposure_readout_control.sv ----
/*
  Self-checking bench for the exposure and readout controller.
  Assumes the grabber model drives link clock and trigger lines.
*/
`timescale 1ns/1ps
module test_camera_exposure_readout_control;
  import cer_pkg::*;
  logic core_clk, reset_n, reg_wr, reg_rd, row_ready, stall;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic link_clk, cc1_in, cc2_in, aux_exposure_trigger_in_in;
  logic frame_valid, line_valid, exposing, row_valid;
  logic [10:0] row_data;
  logic rd_seen, fv_q, lv_q, ex_q;
  int miscompares, n_checks, ex_cnt, d, setup_v;
  logic [15:0] rd_q[$];
  logic [15:0] msk_q[$];
  logic [10:0] row_q[$];
  int len_q[$];

  cer_ctrl i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .cc1_in(cc1_in), .cc2_in(cc2_in), .aux_exposure_trigger_in_in(aux_exposure_trigger_in_in),
    .frame_valid(frame_valid), .line_valid(line_valid),
    .exposing(exposing), .row_data(row_data), .row_valid(row_valid),
    .row_ready(row_ready));
  cer_grabber i_grab (.link_clk(link_clk), .cc1_in(cc1_in),
    .cc2_in(cc2_in), .aux_exposure_trigger_in_in(aux_exposure_trigger_in_in));

  // 100 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("ERROR %0t: %s", $time, what);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // strobes stay put until the next call, so none is set twice per step
  task bus(input logic w, input logic r, input logic [3:0] a,
           input logic [15:0] dt);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= dt;
    @(posedge core_clk);
  endtask : bus

  task wr(input logic [3:0] a, input logic [15:0] dt);
    bus(1'b1, 1'b0, a, dt);
  endtask : wr

  task idle;
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask : idle

  task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  task do_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
  endtask : do_reset

  // 0 exposure over, 1 frame up, 2 rows drained, 3 exposure begun
  task wait_on(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge core_clk);
      if (sel == 0 && exposing === 1'b0) break;
      if (sel == 1 && frame_valid === 1'b1) break;
      if (sel == 2 && row_q.size() == 0) break;
      if (sel == 3 && exposing === 1'b1) break;
    end
    chk(i < lim, "wait timed out");
  endtask : wait_on

  // monitor: each result that appears takes the oldest note
  always @(posedge core_clk)
  begin
    if (rd_seen && rd_q.size() > 0)
      chk((reg_rdata & msk_q.pop_front()) === rd_q.pop_front(), "read");
    if (row_valid === 1'b1 && row_ready && row_q.size() > 0)
      chk(row_data === row_q.pop_front(), "row index");
    if (frame_valid === 1'b1 && !fv_q)
      chk(line_valid === 1'b1 && !lv_q, "frame off line start");
    if (exposing === 1'b1)
      ex_cnt++;
    else
    begin
      if (ex_q && len_q.size() > 0)
      begin
        d = ex_cnt - len_q.pop_front();
        chk(d <= 120 && d >= -120, "exposure length");
      end
      ex_cnt = 0;
    end
    rd_seen = reg_rd;
    fv_q = frame_valid;
    lv_q = line_valid;
    ex_q = exposing;
  end

  // watchdog: well past the roughly 81k cycles the sequence needs
  initial
  begin
    #1000000;
    chk(1'b0, "watchdog expired");
    report_and_stop;
  end

  initial
  begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 16'h0000; row_ready = 1'b0; stall = 1'b0;
    miscompares = 0; n_checks = 0; ex_cnt = 0;
    rd_seen = 1'b0; fv_q = 1'b0; lv_q = 1'b0; ex_q = 1'b0;
    void'($urandom(32'h2c53));
    // receiver ready at random, or held off to fill the buffer
    fork
      forever
      begin
        @(posedge core_clk);
        row_ready <= !stall && ($urandom % 4 != 0);
      end
    join_none
    do_reset;
    // register reset values, clamps, unmapped index, refused pair
    rd(REG_CTRL, 16'h0000, 16'hffff);
    rd(REG_SETUP, 16'h0000, 16'hffff);
    rd(REG_SHUTTER, SHUT_RST, 16'hffff);
    wr(4'h9, 16'h1234);
    rd(4'h9, 16'h0000, 16'hffff);
    wr(REG_SETUP, 16'hfed4);
    rd(REG_SETUP, 16'hff08, 16'hffff);
    wr(REG_SETUP, 16'h0258);
    rd(REG_SETUP, 16'h01ff, 16'hffff);
    setup_v = $urandom_range(759) - 248;
    wr(REG_SETUP, 16'(setup_v));
    rd(REG_SETUP, 16'(setup_v), 16'hffff);
    wr(REG_SHUTTER, 16'h0005);
    rd(REG_SHUTTER, SHUT_MIN_US, 16'hffff);
    wr(REG_CTRL, 16'h0001);
    wr(REG_CTRL, 16'h0023);
    rd(REG_CTRL, 16'h0021, 16'hffff);
    idle;
    row_q = '{PART_FIRST, PART_FIRST + 11'h001};
    wait_on(2, 10000);
    // full readout with receiver stalled over three line starts
    do_reset;
    stall = 1'b1;
    row_q = '{11'h000, 11'h001, 11'h002, 11'h003};
    repeat (12600) @(posedge core_clk);
    stall = 1'b0;
    wait_on(2, 9000);
    // draft readout keeps two rows of eight
    do_reset;
    wr(REG_CTRL, 16'h0002);
    idle;
    row_q = '{11'h000, 11'h001, 11'h008};
    wait_on(2, 14000);
    // fixed mode, control line one, positive polarity
    do_reset;
    wr(REG_SHUTTER, 16'h0064);
    wr(REG_CTRL, 16'h000c);
    idle;
    len_q.push_back(10000);
    i_grab.pulse(1'b0, 1'b1, 2000);
    wait_on(3, 400);
    wait_on(0, 10500);
    wait_on(1, 3300);
    // pulse-width mode, auxiliary input, negative polarity
    do_reset;
    i_grab.set_line(1'b1, 1'b1);
    @(posedge core_clk);
    wr(REG_CTRL, 16'h0054);
    idle;
    len_q.push_back(4500);
    i_grab.pulse(1'b1, 1'b0, 40000);
    chk(exposing === 1'b1, "tail missing");
    wait_on(0, 1000);
    wait_on(1, 3300);
    // a fixed and a pulse-width exposure stacked, then a readout request
    do_reset;
    wr(REG_SHUTTER, 16'h0064);
    wr(REG_CTRL, 16'h002c);
    idle;
    len_q.push_back(10000);
    i_grab.pulse(1'b0, 1'b1, 2000);
    wait_on(3, 400);
    wait_on(0, 10500);
    // second exposure switched to pulse-width: one line plus the tail
    wr(REG_CTRL, 16'h003c);
    idle;
    len_q.push_back(3628);
    i_grab.pulse(1'b0, 1'b1, 31250);
    wait_on(3, 400);
    wait_on(0, 1000);
    repeat (3200) @(posedge core_clk);
    chk(frame_valid === 1'b0, "frame before request");
    rd(REG_STATUS, 16'h0200, 16'hff00);
    idle;
    i_grab.request(40000);
    wait_on(1, 3300);
    report_and_stop;
  end
endmodule : test_camera_exposure_readout_control
